// file: ordc_config.sv
/*
 holds the configuration bank of an osd character generator with its
 power-on defaults, the indirect attribute state and the output ports.
 assumes a command decoder on the same clock presents register writes
 as a one-cycle strobe with index and data, and a display pipeline feeds
 attribute updates from space and carriage-return codes.
*/
`include "ordc_defs.svh"

module ordc_config #(
    parameter logic PORT_C_RESET_HIGH = 1'b1,
    parameter logic SPACE_OPAQUE = 1'b0,
    parameter ordc_pkg::ordc_drive_t DRIVE_A = ordc_pkg::ORDC_DRV_PUSH_PULL,
    parameter ordc_pkg::ordc_drive_t DRIVE_B = ordc_pkg::ORDC_DRV_PUSH_PULL,
    parameter ordc_pkg::ordc_drive_t DRIVE_C = ordc_pkg::ORDC_DRV_PUSH_PULL
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    // register write strobe from the command decoder
    input wire logic reg_wr,
    input wire logic [2:0] reg_idx,
    input wire logic [5:0] reg_wdata,
    // port data write
    input wire logic port_wr,
    input wire logic [2:0] port_wdata,
    // attribute updates from the display pipeline
    input wire logic space_code,
    input wire logic space_acm,
    input wire logic [3:0] space_colour,
    input wire logic cr_code,
    input wire logic [1:0] cr_size,
    input wire logic cr_end,
    // raw pin levels
    input wire logic hsync_pin,
    input wire logic vsync_pin,
    output logic [1:0] scan_std,
    output logic out_polarity,
    output logic display_enable,
    output logic hsync_active,
    output logic vsync_active,
    output logic [1:0] shadow_mode,
    output logic [1:0] blink_rate,
    output logic [1:0] blink_duty,
    output logic shared_pin_sel,
    output logic [3:0] frame_colour,
    output logic [1:0] cmd_bank,
    output logic active_char_monitor,
    output logic [3:0] word_colour,
    output logic [1:0] char_size,
    output logic end_of_display_flag,
    output logic space_opaque,
    output logic out_port_a,
    output logic out_port_a_oe,
    output logic out_port_b,
    output logic out_port_b_oe,
    output logic out_port_c,
    output logic out_port_c_oe
);
    logic [3:0] scan_polarity_enable_ctrl;
    logic [3:0] sync_polarity_shadow_ctrl;
    logic [3:0] blink_ctrl;
    logic shared_pin_ctrl;
    logic [5:0] frame_colour_bank_ctrl;
    logic [3:0] next_scan;
    logic [3:0] next_sync;
    logic [3:0] next_blink;
    logic next_shared;
    logic [5:0] next_frame;
    logic acm_q;
    logic [3:0] wcol_q;
    logic [1:0] size_q;
    logic eod_q;
    logic next_acm;
    logic [3:0] next_wcol;
    logic [1:0] next_size;
    logic next_eod;
    logic [2:0] port_q;
    logic [2:0] next_port;
    logic hs_sync;
    logic vs_sync;
    logic hs_act_q;
    logic vs_act_q;
    logic next_hs_act;
    logic next_vs_act;
    logic opaque_q;
    logic next_opaque;
    logic pa_out;
    logic pa_oe;
    logic pb_out;
    logic pb_oe;
    logic pc_out;
    logic pc_oe;
    logic pa_out_q;
    logic pa_oe_q;
    logic pb_out_q;
    logic pb_oe_q;
    logic pc_out_q;
    logic pc_oe_q;

    // pad enable for a level: push-pull always drives, the others only pull low
    function automatic logic drive_oe(
        input ordc_pkg::ordc_drive_t drive,
        input logic level
    );
        return (drive == ordc_pkg::ORDC_DRV_PUSH_PULL) | ~level;
    endfunction

    localparam logic PA_OE_RST = drive_oe(DRIVE_A, 1'b1);
    localparam logic PB_OE_RST = drive_oe(DRIVE_B, 1'b1);
    localparam logic PC_OE_RST = drive_oe(DRIVE_C, PORT_C_RESET_HIGH);

    // host-written bank; every register loads a power-on default at reset
    always_comb begin
        next_scan = scan_polarity_enable_ctrl;
        next_sync = sync_polarity_shadow_ctrl;
        next_blink = blink_ctrl;
        next_shared = shared_pin_ctrl;
        next_frame = frame_colour_bank_ctrl;
        if (clk_en && reg_wr) begin
            if (reg_idx == `ORDC_REG_SCAN) begin
                next_scan = reg_wdata[3:0];
            end else if (reg_idx == `ORDC_REG_SYNC) begin
                next_sync = reg_wdata[3:0];
            end else if (reg_idx == `ORDC_REG_BLINK) begin
                next_blink = reg_wdata[3:0];
            end else if (reg_idx == `ORDC_REG_SHARED) begin
                next_shared = reg_wdata[0];
            end else if (reg_idx == `ORDC_REG_FRAME) begin
                next_frame = reg_wdata;
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            scan_polarity_enable_ctrl <= `ORDC_SCAN_RST;
            sync_polarity_shadow_ctrl <= `ORDC_SYNC_RST;
            blink_ctrl <= `ORDC_BLINK_RST;
            shared_pin_ctrl <= `ORDC_SHARED_RST;
            frame_colour_bank_ctrl <= `ORDC_FRAME_RST;
        end else begin
            scan_polarity_enable_ctrl <= next_scan;
            sync_polarity_shadow_ctrl <= next_sync;
            blink_ctrl <= next_blink;
            shared_pin_ctrl <= next_shared;
            frame_colour_bank_ctrl <= next_frame;
        end
    end

    // indirect attributes, changed only by display codes
    always_comb begin
        next_acm = acm_q;
        next_wcol = wcol_q;
        next_size = size_q;
        next_eod = eod_q;
        if (clk_en && space_code) begin
            next_acm = space_acm;
            next_wcol = space_colour;
        end
        if (clk_en && cr_code) begin
            next_size = cr_size;
            next_eod = cr_end;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acm_q <= `ORDC_ACM_RST;
            wcol_q <= `ORDC_WCOL_RST;
            size_q <= `ORDC_SIZE_RST;
            eod_q <= `ORDC_EOD_RST;
        end else begin
            acm_q <= next_acm;
            wcol_q <= next_wcol;
            size_q <= next_size;
            eod_q <= next_eod;
        end
    end

    // sync inputs: resolve programmed polarity after synchronising
    ordc_sync2 u_hs (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(hsync_pin),
        .sync_out(hs_sync)
    );

    ordc_sync2 u_vs (
        .clock(clock),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(vsync_pin),
        .sync_out(vs_sync)
    );

    // ports: option-driven reset level, then host data
    always_comb begin
        next_port = port_q;
        next_hs_act = hs_act_q;
        next_vs_act = vs_act_q;
        next_opaque = opaque_q;
        if (clk_en) begin
            if (port_wr) begin
                next_port = port_wdata;
            end
            next_hs_act = hs_sync ~^ sync_polarity_shadow_ctrl[`ORDC_HSYNC_POL_B];
            next_vs_act = vs_sync ~^ sync_polarity_shadow_ctrl[`ORDC_VSYNC_POL_B];
            // option only matters in box shadowing mode
            next_opaque = SPACE_OPAQUE & (next_sync[`ORDC_SHADOW_F] == `ORDC_SHADOW_BOX);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            port_q <= {PORT_C_RESET_HIGH, 2'h3};
            hs_act_q <= 1'h0;
            vs_act_q <= 1'h0;
            opaque_q <= 1'h0;
        end else begin
            port_q <= next_port;
            hs_act_q <= next_hs_act;
            vs_act_q <= next_vs_act;
            opaque_q <= next_opaque;
        end
    end

    ordc_port_drv #(.DRIVE(DRIVE_A)) u_pa (
        .level(next_port[0]),
        .pin_out(pa_out),
        .pin_oe(pa_oe)
    );

    ordc_port_drv #(.DRIVE(DRIVE_B)) u_pb (
        .level(next_port[1]),
        .pin_out(pb_out),
        .pin_oe(pb_oe)
    );

    ordc_port_drv #(.DRIVE(DRIVE_C)) u_pc (
        .level(next_port[2]),
        .pin_out(pc_out),
        .pin_oe(pc_oe)
    );

    // pad outputs registered so they stand straight from flip-flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pa_out_q <= 1'h1;
            pa_oe_q <= PA_OE_RST;
            pb_out_q <= 1'h1;
            pb_oe_q <= PB_OE_RST;
            pc_out_q <= PORT_C_RESET_HIGH;
            pc_oe_q <= PC_OE_RST;
        end else begin
            pa_out_q <= pa_out;
            pa_oe_q <= pa_oe;
            pb_out_q <= pb_out;
            pb_oe_q <= pb_oe;
            pc_out_q <= pc_out;
            pc_oe_q <= pc_oe;
        end
    end

    // field views; every one comes straight from a flop
    assign scan_std = scan_polarity_enable_ctrl[`ORDC_SCAN_STD_F];
    assign out_polarity = scan_polarity_enable_ctrl[`ORDC_OUT_POL_B];
    assign display_enable = scan_polarity_enable_ctrl[`ORDC_ENABLE_B];
    assign hsync_active = hs_act_q;
    assign vsync_active = vs_act_q;
    assign shadow_mode = sync_polarity_shadow_ctrl[`ORDC_SHADOW_F];
    assign blink_rate = blink_ctrl[`ORDC_BLINK_RATE_F];
    assign blink_duty = blink_ctrl[`ORDC_BLINK_DUTY_F];
    assign shared_pin_sel = shared_pin_ctrl;
    assign frame_colour = frame_colour_bank_ctrl[`ORDC_FRAME_COL_F];
    assign cmd_bank = frame_colour_bank_ctrl[`ORDC_BANK_F];
    assign active_char_monitor = acm_q;
    assign word_colour = wcol_q;
    assign char_size = size_q;
    assign end_of_display_flag = eod_q;
    assign space_opaque = opaque_q;
    assign out_port_a = pa_out_q;
    assign out_port_a_oe = pa_oe_q;
    assign out_port_b = pb_out_q;
    assign out_port_b_oe = pb_oe_q;
    assign out_port_c = pc_out_q;
    assign out_port_c_oe = pc_oe_q;
endmodule // ordc_config

// file: ordc_config_monitor.sv
/*
 assertions on the ports of the osd configuration bank.
 assumes it is bound to ordc_config.
*/
module ordc_config_monitor #(
    parameter logic PORT_C_RESET_HIGH = 1'b1,
    parameter logic SPACE_OPAQUE = 1'b0,
    parameter ordc_pkg::ordc_drive_t DRIVE_A = ordc_pkg::ORDC_DRV_PUSH_PULL,
    parameter ordc_pkg::ordc_drive_t DRIVE_C = ordc_pkg::ORDC_DRV_PUSH_PULL
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [2:0] reg_idx,
    input wire logic [5:0] reg_wdata,
    input wire logic port_wr,
    input wire logic [2:0] port_wdata,
    input wire logic [1:0] scan_std,
    input wire logic out_polarity,
    input wire logic display_enable,
    input wire logic [1:0] shadow_mode,
    input wire logic [1:0] blink_rate,
    input wire logic [1:0] blink_duty,
    input wire logic [3:0] frame_colour,
    input wire logic [1:0] cmd_bank,
    input wire logic [3:0] word_colour,
    input wire logic [1:0] char_size,
    input wire logic space_opaque,
    input wire logic out_port_a,
    input wire logic out_port_a_oe,
    input wire logic out_port_b,
    input wire logic out_port_c,
    input wire logic out_port_c_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [3:0] wd_lo;
    assign wd_lo = reg_wdata[3:0];
    property p_scan_rst;
        $rose(reset_n) |-> scan_std == 2'h0 && out_polarity && !display_enable;
    endproperty
    a_scan_rst: assert property (p_scan_rst) else $error("scan defaults wrong");
    property p_shadow_rst;
        $rose(reset_n) |-> shadow_mode == 2'h1 && {blink_rate, blink_duty} == 4'h0;
    endproperty
    a_shadow_rst: assert property (p_shadow_rst) else $error("shadow defaults wrong");
    property p_colour_rst;
        $rose(reset_n) |-> {frame_colour, cmd_bank, word_colour, char_size} == 12'h208;
    endproperty
    a_colour_rst: assert property (p_colour_rst) else $error("colour defaults wrong");
    property p_port_rst;
        $rose(reset_n) |-> out_port_a && out_port_b && out_port_c == PORT_C_RESET_HIGH;
    endproperty
    a_port_rst: assert property (p_port_rst) else $error("port defaults wrong");
    property p_hold;
        !(reg_wr && clk_en && reg_idx == 3'h0) |=> $stable({scan_std, out_polarity, display_enable});
    endproperty
    a_hold: assert property (p_hold) else $error("register changed unwritten");
    property p_write;
        reg_wr && clk_en && reg_idx == 3'h2 |=> {blink_rate, blink_duty} == $past(wd_lo);
    endproperty
    a_write: assert property (p_write) else $error("blink write lost");
    property p_opaque;
        $stable(shadow_mode) |-> space_opaque == (SPACE_OPAQUE && shadow_mode == 2'h2);
    endproperty
    a_opaque: assert property (p_opaque) else $error("space style wrong");
    property p_drive;
        out_port_a_oe == (DRIVE_A == ordc_pkg::ORDC_DRV_PUSH_PULL || !out_port_a) &&
        out_port_c_oe == (DRIVE_C == ordc_pkg::ORDC_DRV_PUSH_PULL || !out_port_c);
    endproperty
    a_drive: assert property (p_drive) else $error("port enable wrong");
    property p_port_wr;
        port_wr && clk_en |=> {out_port_c, out_port_b, out_port_a} == $past(port_wdata);
    endproperty
    a_port_wr: assert property (p_port_wr) else $error("port write lost");
    c_box: cover property (shadow_mode == 2'h2 && space_opaque);
    c_refused: cover property (reg_wr && clk_en && reg_idx > 3'h4);
    c_frozen: cover property (reg_wr && !clk_en);
endmodule // ordc_config_monitor
bind ordc_config ordc_config_monitor #(.PORT_C_RESET_HIGH(PORT_C_RESET_HIGH),
    .SPACE_OPAQUE(SPACE_OPAQUE), .DRIVE_A(DRIVE_A), .DRIVE_C(DRIVE_C)) mon_i (.*);

// file: ordc_defs.svh
/*
 holds reset defaults, field positions and register indices of the osd
 configuration bank as macros. assumes inclusion by bare name only.
*/
`ifndef ORDC_DEFS_SVH
`define ORDC_DEFS_SVH

// register indices, written by the command decoder
`define ORDC_REG_SCAN   3'h0
`define ORDC_REG_SYNC   3'h1
`define ORDC_REG_BLINK  3'h2
`define ORDC_REG_SHARED 3'h3
`define ORDC_REG_FRAME  3'h4

// scan_polarity_enable_ctrl: [3:2] scan std, [1] out polarity, [0] enable
`define ORDC_SCAN_RST   4'h2
// sync_polarity_shadow_ctrl: [3] hsync pol, [2] vsync pol, [1:0] shadow mode
`define ORDC_SYNC_RST   4'h1
// blink_ctrl: [3:2] rate, [1:0] duty
`define ORDC_BLINK_RST  4'h0
`define ORDC_SHARED_RST 1'h0
// frame_colour_bank_ctrl: [5:2] r g b i, [1:0] command bank
`define ORDC_FRAME_RST  6'h08

// field positions inside the bank registers
`define ORDC_SCAN_STD_F 3:2
`define ORDC_OUT_POL_B 1
`define ORDC_ENABLE_B 0
`define ORDC_HSYNC_POL_B 3
`define ORDC_VSYNC_POL_B 2
`define ORDC_SHADOW_F 1:0
`define ORDC_BLINK_RATE_F 3:2
`define ORDC_BLINK_DUTY_F 1:0
`define ORDC_FRAME_COL_F 5:2
`define ORDC_BANK_F 1:0
// shadow mode code that selects box shadowing
`define ORDC_SHADOW_BOX 2'h2

// indirect attribute state: {acm, r g b i, size[1:0], end flag}
`define ORDC_ACM_RST    1'h0
`define ORDC_WCOL_RST   4'h2
`define ORDC_SIZE_RST   2'h0
`define ORDC_EOD_RST    1'h0

`endif

// file: ordc_host.sv
/*
 host model that issues one-cycle register write strobes.
 assumes its caller runs just after a rising clock edge.
*/
module ordc_host (
    input wire logic clock,
    output logic reg_wr,
    output logic [2:0] reg_idx,
    output logic [5:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_idx = 3'h0;
        reg_wdata = 6'h0;
    end
    task automatic write(input logic [2:0] idx, input logic [5:0] data);
        reg_wr = 1'b1;
        reg_idx = idx;
        reg_wdata = data;
        @(posedge clock);
        #2;
        reg_wr = 1'b0;
        // inverse on release, so stale data never looks valid
        reg_idx = ~idx;
        reg_wdata = ~data;
    endtask
endmodule // ordc_host

// file: ordc_pkg.sv
/*
 holds the types of the osd configuration bank.
 assumes ordc_defs.svh for all numeric values.
*/
package ordc_pkg;
    typedef enum logic [1:0] {
        ORDC_DRV_PULLUP,
        ORDC_DRV_OPEN_DRAIN,
        ORDC_DRV_PUSH_PULL
    } ordc_drive_t;
endpackage

// file: ordc_port_drv.sv
/*
 holds one output port driver with a build-time drive style.
 assumes the surrounding pad resolves output and enable to a wire level.
*/
module ordc_port_drv #(
    parameter ordc_pkg::ordc_drive_t DRIVE = ordc_pkg::ORDC_DRV_PUSH_PULL
) (
    input wire logic level,
    output logic pin_out,
    output logic pin_oe
);
    // pull-up and open-drain only drive low; the high comes from outside
    always_comb begin
        pin_out = level;
        pin_oe = (DRIVE == ordc_pkg::ORDC_DRV_PUSH_PULL) ? 1'b1 : ~level;
    end
endmodule // ordc_port_drv

// file: ordc_sync2.sv
/*
 holds a two flip-flop level synchroniser.
 assumes an asynchronous active low reset and a clock enable.
*/
module ordc_sync2 (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    logic meta;
    logic next_meta;
    logic next_sync_out;

    always_comb begin
        next_meta = clk_en ? async_in : meta;
        next_sync_out = clk_en ? meta : sync_out;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // resets high: sync pins idle high under the default low-active polarity
            meta <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule // ordc_sync2

// file: tb_osd_reset_default_config.sv
/*
 self-checking bench of the osd configuration bank against an integer and queue model.
 assumes ordc_host as the command source and the bound monitor.
*/
module tb_osd_reset_default_config;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, reset_n, clk_en, reg_wr, port_wr, space_code, space_acm, cr_code, cr_end;
    logic hsync_pin, vsync_pin, out_polarity, display_enable, hsync_active, vsync_active;
    logic shared_pin_sel, active_char_monitor, end_of_display_flag, space_opaque;
    logic out_port_a, out_port_a_oe, out_port_b, out_port_b_oe, out_port_c, out_port_c_oe;
    logic [1:0] scan_std, shadow_mode, blink_rate, blink_duty, cmd_bank, char_size, cr_size;
    logic [2:0] reg_idx, port_wdata;
    logic [3:0] frame_colour, word_colour, space_colour;
    logic [5:0] reg_wdata;
    logic [31:0] seed, r;
    logic [7:0] attr, ports;
    int num_errors = 0, n_checks = 0, cycles = 0;
    int m[$];
    // port c resets low and drains open, to reach both option branches
    ordc_config #(.PORT_C_RESET_HIGH(1'b0), .SPACE_OPAQUE(1'b1),
        .DRIVE_C(ordc_pkg::ORDC_DRV_OPEN_DRAIN)) ordc_config_i (.*);
    ordc_host ordc_host_i (.clock, .reg_wr, .reg_idx, .reg_wdata);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic do_reset(input int n);
        reset_n = 1'b0;
        m = '{2, 1, 0, 0, 8};
        attr = 8'h10;
        ports = 8'h03;
        repeat (n) @(posedge clock);
        #2;
        reset_n = 1'b1;
        repeat (4) @(posedge clock);
        #2;
        chk_all();
    endtask
    task automatic chk_all();
        chk(8'({scan_std, out_polarity, display_enable}), 8'(m[0]));
        chk(8'({hsync_active, vsync_active}), 8'({hsync_pin == m[1][3], vsync_pin == m[1][2]}));
        chk(8'(shadow_mode), 8'(m[1][1:0]));
        chk(8'({blink_rate, blink_duty}), 8'(m[2]));
        chk(8'(shared_pin_sel), 8'(m[3]));
        chk(8'({frame_colour, cmd_bank}), 8'(m[4]));
        chk({active_char_monitor, word_colour, char_size, end_of_display_flag}, attr);
        chk(8'({out_port_c, out_port_b, out_port_a}), ports);
        chk(8'({out_port_c_oe, out_port_b_oe, out_port_a_oe}), {5'h0, !ports[2], 2'h3});
        chk(8'(space_opaque), 8'(m[1][1:0] == 2));
    endtask
    task automatic step(input logic [31:0] v);
        int mask[5] = '{15, 15, 15, 1, 63};
        clk_en = v[0] | v[1];
        {hsync_pin, vsync_pin, space_code, space_acm, space_colour} = v[7:0];
        {cr_code, cr_size, cr_end, port_wr, port_wdata} = v[15:8];
        ordc_host_i.write(v[18:16], v[24:19]);
        if (clk_en) begin
            if (v[18:16] < 3'h5) m[v[18:16]] = int'(v[24:19]) & mask[v[18:16]];
            if (space_code) attr[7:3] = {space_acm, space_colour};
            if (cr_code) attr[2:0] = {cr_size, cr_end};
            if (port_wr) ports = 8'(port_wdata);
        end
        {clk_en, space_code, cr_code, port_wr} = 4'h8;
        repeat (4) @(posedge clock);
        #2;
        chk_all();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {clk_en, port_wr, space_code, space_acm, cr_code, cr_end, hsync_pin, vsync_pin} = 8'h80;
        {space_colour, cr_size, port_wdata} = 9'h0;
        seed = 32'h00011972;
        do_reset(6);
        $display("test reset defaults done");
        for (int i = 0; i < 40; i++) begin
            repeat (7) seed = lfsr(seed);
            r = seed;
            // first steps sweep every index and all four shadow codes
            if (i < 12) r[1:0] = 2'h3;
            if (i >= 4 && i < 12) r[18:16] = 3'(i - 4);
            if (i < 4) r[24:16] = {6'(i), 3'h1};
            step(r);
        end
        $display("test register writes done");
        do_reset(2);
        $display("test second reset done");
        complete_run();
    end
endmodule // tb_osd_reset_default_config
